// [logic/fspp_defs.svh]
// constants for the flash serial programming port
`ifndef FSPP_DEFS_SVH
`define FSPP_DEFS_SVH
`define FSPP_CLK_HZ 100000000
`define FSPP_BAUD 115200
`define FSPP_BIT_CYC (`FSPP_CLK_HZ / `FSPP_BAUD)
`define FSPP_HALF_CYC (`FSPP_BIT_CYC / 2)
`define FSPP_CMD_COMM 8'h01
`define FSPP_CMD_CHIP_ERASE 8'h20
`define FSPP_CMD_BLOCK_ERASE 8'h22
`define FSPP_CMD_WRITE 8'h40
`define FSPP_CMD_CHECKSUM 8'hB0
`define FSPP_CMD_SECURITY 8'hA0
`define FSPP_RSP_ACK 8'h06
`define FSPP_RSP_NAK 8'h15
`define FSPP_ERASED 8'hFF
`define FSPP_SEC_BLOCK 0
`define FSPP_SEC_CHIP 1
`define FSPP_SEC_WRITE 2
`endif

// [logic/fspp_pkg.sv]
// types for the flash serial programming port
package fspp_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ARG0 = 4'h1,
    ST_ARG1 = 4'h2,
    ST_ARG2 = 4'h3,
    ST_ARG3 = 4'h4,
    ST_DATA = 4'h5,
    ST_EXEC = 4'h6,
    ST_VERIFY = 4'h7,
    ST_SUM_TX = 4'h8,
    ST_RESP = 4'h9,
    ST_WAIT = 4'hA
  } fspp_state_t;
  typedef struct packed {
    logic rd;
    logic oe;
    logic wr;
  } fspp_link_t;
endpackage : fspp_pkg

// [logic/fspp_top.sv]
// flash programming port: single-wire uart command sequencer with its flash array
`timescale 1ns/1ps
`include "fspp_defs.svh"
module fspp_top #(
  parameter int ADDR_W = 12,
  parameter int BLK_W = 8,
  parameter int NUM_BLK = 16,
  parameter int BAUD_DIV = `FSPP_BIT_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // pin select and link pins
  input wire logic link_sel,
  input wire logic osc_in_pin_i,
  output logic osc_in_pin_o,
  output logic osc_in_pin_oe,
  input wire logic osc_out_pin_i,
  output logic osc_out_pin_o,
  output logic osc_out_pin_oe,
  // device state
  output logic prog_mode,
  output logic ports_hold_reset,
  output logic [2:0] security,
  // self programming
  input wire logic self_prog_busy,
  input wire logic irq_req,
  output logic irq_grant
);
  localparam int DEPTH = 1 << ADDR_W;
  localparam logic [15:0] BIT_CYC = 16'(BAUD_DIV);
  localparam logic [15:0] HALF_CYC = 16'(BAUD_DIV / 2);

  logic [7:0] mem [DEPTH];
  fspp_pkg::fspp_state_t st_q;
  fspp_pkg::fspp_link_t link;

  // receiver
  logic rx_busy_q, rx_v_q;
  logic [15:0] rx_cnt_q;
  logic [3:0] rx_bit_q;
  logic [7:0] rx_sh_q, rx_byte_q;
  logic tx_busy_q;
  always_ff @(posedge mclk) begin
    rx_v_q <= 1'b0;
    if (!reset_n) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q <= 16'h0000;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 8'h00;
      rx_byte_q <= 8'h00;
    end else if (!rx_busy_q) begin
      if (!link.rd && !tx_busy_q) begin
        rx_busy_q <= 1'b1;
        rx_cnt_q <= HALF_CYC;
        rx_bit_q <= 4'h0;
      end
    end else if (rx_cnt_q != 16'h0000) begin
      rx_cnt_q <= rx_cnt_q - 16'h0001;
    end else begin
      rx_cnt_q <= BIT_CYC - 16'h0001;
      rx_bit_q <= rx_bit_q + 4'h1;
      if (rx_bit_q == 4'h0 && link.rd) begin
        rx_busy_q <= 1'b0;
      end else if (rx_bit_q >= 4'h1 && rx_bit_q <= 4'h8) begin
        rx_sh_q <= {link.rd, rx_sh_q[7:1]};
      end else if (rx_bit_q == 4'h9) begin
        rx_busy_q <= 1'b0;
        rx_v_q <= link.rd;
        rx_byte_q <= rx_sh_q;
      end
    end
  end

  // transmitter
  logic tx_go, tx_done_q;
  logic [7:0] tx_data;
  logic [15:0] tx_cnt_q;
  logic [3:0] tx_bit_q;
  logic [9:0] tx_sh_q;
  // pin select; the drive side mirrors the transmitter
  assign link = '{rd: link_sel ? osc_out_pin_i : osc_in_pin_i, oe: tx_busy_q, wr: tx_sh_q[0]};
  always_ff @(posedge mclk) begin
    tx_done_q <= 1'b0;
    if (!reset_n) begin
      tx_busy_q <= 1'b0;
      tx_cnt_q <= 16'h0000;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 10'h3FF;
    end else if (!tx_busy_q) begin
      if (tx_go) begin
        tx_busy_q <= 1'b1;
        tx_sh_q <= {1'b1, tx_data, 1'b0};
        tx_cnt_q <= BIT_CYC - 16'h0001;
        tx_bit_q <= 4'h0;
      end
    end else if (tx_cnt_q != 16'h0000) begin
      tx_cnt_q <= tx_cnt_q - 16'h0001;
    end else if (tx_bit_q == 4'h9) begin
      tx_busy_q <= 1'b0;
      tx_done_q <= 1'b1;
    end else begin
      tx_cnt_q <= BIT_CYC - 16'h0001;
      tx_bit_q <= tx_bit_q + 4'h1;
      tx_sh_q <= {1'b1, tx_sh_q[9:1]};
    end
  end

  // drive only while sending, else release
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      osc_in_pin_o <= 1'b1;
      osc_in_pin_oe <= 1'b0;
      osc_out_pin_o <= 1'b1;
      osc_out_pin_oe <= 1'b0;
    end else begin
      osc_in_pin_o <= link.wr;
      osc_out_pin_o <= link.wr;
      osc_in_pin_oe <= link.oe && !link_sel;
      osc_out_pin_oe <= link.oe && link_sel;
    end
  end

  // sequencer
  logic [7:0] cmd_q, resp_q, sum_q;
  logic [ADDR_W-1:0] addr_q, end_q;
  logic ok_q;
  logic [7:0] rd_byte;
  assign rd_byte = mem[addr_q];
  assign tx_go = (st_q == fspp_pkg::ST_RESP || st_q == fspp_pkg::ST_SUM_TX) && !tx_busy_q && !tx_done_q;
  assign tx_data = (st_q == fspp_pkg::ST_SUM_TX) ? sum_q : resp_q;

  logic blocked;
  logic [2:0] security_q;
  always_comb begin
    unique case (cmd_q)
      `FSPP_CMD_CHIP_ERASE: blocked = security_q[`FSPP_SEC_CHIP];
      `FSPP_CMD_BLOCK_ERASE: blocked = |security_q;
      `FSPP_CMD_WRITE: blocked = security_q[`FSPP_SEC_WRITE];
      default: blocked = 1'b0;
    endcase
  end
  logic valid_cmd;
  assign valid_cmd = cmd_q == `FSPP_CMD_COMM || cmd_q == `FSPP_CMD_CHIP_ERASE ||
    cmd_q == `FSPP_CMD_BLOCK_ERASE || cmd_q == `FSPP_CMD_WRITE ||
    cmd_q == `FSPP_CMD_CHECKSUM || cmd_q == `FSPP_CMD_SECURITY;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st_q <= fspp_pkg::ST_IDLE;
      cmd_q <= 8'h00;
      resp_q <= 8'h00;
      sum_q <= 8'h00;
      addr_q <= '0;
      end_q <= '0;
      ok_q <= 1'b1;
      prog_mode <= 1'b0;
      security_q <= 3'h0;
    end else begin
      unique case (st_q)
        fspp_pkg::ST_IDLE: if (rx_v_q) begin
          cmd_q <= rx_byte_q;
          sum_q <= 8'h00;
          ok_q <= 1'b1;
          st_q <= fspp_pkg::ST_ARG0;
        end
        fspp_pkg::ST_ARG0: begin
          if (cmd_q == `FSPP_CMD_COMM) begin
            prog_mode <= 1'b1;
            resp_q <= `FSPP_RSP_ACK;
            st_q <= fspp_pkg::ST_RESP;
          end else if (!prog_mode || !valid_cmd) begin
            resp_q <= `FSPP_RSP_NAK;
            st_q <= fspp_pkg::ST_RESP;
          end else if (cmd_q == `FSPP_CMD_CHIP_ERASE) begin
            addr_q <= '0;
            end_q <= '1;
            st_q <= fspp_pkg::ST_EXEC;
          end else begin
            st_q <= fspp_pkg::ST_ARG1;
          end
        end
        fspp_pkg::ST_ARG1: if (rx_v_q) begin
          if (cmd_q == `FSPP_CMD_SECURITY) begin
            security_q <= security_q | rx_byte_q[2:0];
            resp_q <= `FSPP_RSP_ACK;
            st_q <= fspp_pkg::ST_RESP;
          end else if (cmd_q == `FSPP_CMD_BLOCK_ERASE) begin
            addr_q <= ADDR_W'({rx_byte_q, BLK_W'(0)});
            end_q <= ADDR_W'({rx_byte_q, {BLK_W{1'b1}}});
            ok_q <= rx_byte_q < 8'(NUM_BLK);
            st_q <= fspp_pkg::ST_EXEC;
          end else begin
            addr_q <= ADDR_W'({rx_byte_q, 8'h00});
            st_q <= fspp_pkg::ST_ARG2;
          end
        end
        fspp_pkg::ST_ARG2: if (rx_v_q) begin
          addr_q <= addr_q | ADDR_W'(rx_byte_q);
          st_q <= fspp_pkg::ST_ARG3;
        end
        fspp_pkg::ST_ARG3: if (rx_v_q) begin
          end_q <= addr_q + ADDR_W'(rx_byte_q);
          st_q <= (cmd_q == `FSPP_CMD_WRITE) ? fspp_pkg::ST_DATA : fspp_pkg::ST_EXEC;
        end
        fspp_pkg::ST_DATA: if (rx_v_q) begin
          if (!blocked) begin
            mem[addr_q] <= rx_byte_q;
          end
          sum_q <= rx_byte_q;
          st_q <= fspp_pkg::ST_VERIFY;
        end
        fspp_pkg::ST_VERIFY: begin
          ok_q <= ok_q && (rd_byte == sum_q) && !blocked;
          addr_q <= addr_q + ADDR_W'(1);
          if (addr_q == end_q) begin
            resp_q <= (ok_q && (rd_byte == sum_q) && !blocked) ? `FSPP_RSP_ACK : `FSPP_RSP_NAK;
            st_q <= fspp_pkg::ST_RESP;
          end else begin
            st_q <= fspp_pkg::ST_DATA;
          end
        end
        fspp_pkg::ST_EXEC: begin
          if (blocked || !ok_q) begin
            resp_q <= `FSPP_RSP_NAK;
            st_q <= fspp_pkg::ST_RESP;
          end else begin
            if (cmd_q == `FSPP_CMD_CHECKSUM) begin
              sum_q <= sum_q + rd_byte;
            end else begin
              mem[addr_q] <= `FSPP_ERASED;
            end
            addr_q <= addr_q + ADDR_W'(1);
            if (addr_q == end_q) begin
              resp_q <= `FSPP_RSP_ACK;
              st_q <= (cmd_q == `FSPP_CMD_CHECKSUM) ? fspp_pkg::ST_SUM_TX : fspp_pkg::ST_RESP;
              // chip erase clears only block and write prohibits
              if (cmd_q == `FSPP_CMD_CHIP_ERASE) begin
                security_q <= security_q & 3'h2;
              end
            end
          end
        end
        fspp_pkg::ST_SUM_TX: if (tx_done_q) begin
          st_q <= fspp_pkg::ST_RESP;
        end
        fspp_pkg::ST_RESP: if (tx_done_q) begin
          st_q <= fspp_pkg::ST_IDLE;
        end
        default: st_q <= fspp_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ports_hold_reset <= 1'b0;
      security <= 3'h0;
      irq_grant <= 1'b0;
    end else begin
      ports_hold_reset <= prog_mode;
      security <= security_q;
      irq_grant <= irq_req && !self_prog_busy && !prog_mode;
    end
  end
endmodule : fspp_top

// [testbench/fspp_monitor.sv]
// pin-level assertions for the flash programming port
`timescale 1ns/1ps
module fspp_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // link pins
  input wire logic link_sel,
  input wire logic osc_in_pin_o,
  input wire logic osc_in_pin_oe,
  input wire logic osc_out_pin_oe,
  // device state
  input wire logic prog_mode,
  input wire logic ports_hold_reset,
  input wire logic [2:0] security,
  // self programming
  input wire logic self_prog_busy,
  input wire logic irq_req,
  input wire logic irq_grant
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_hold_follows_mode: assert property (ports_hold_reset == $past(prog_mode))
    else $error("pin hold lags mode wrongly");
  a_mode_stays_set: assert property (prog_mode |=> prog_mode)
    else $error("mode dropped");
  a_irq_grant_cause: assert property (irq_grant |-> $past(irq_req) && !$past(self_prog_busy) && !$past(prog_mode))
    else $error("grant without cause");
  a_irq_grant_given: assert property (irq_req && !self_prog_busy && !prog_mode |=> irq_grant)
    else $error("grant missing");
  a_in_pin_quiet: assert property (link_sel |-> !osc_in_pin_oe)
    else $error("unused pin driven");
  a_out_pin_quiet: assert property (!link_sel |-> !osc_out_pin_oe)
    else $error("unused pin driven");
  a_start_bit_low: assert property ($rose(osc_in_pin_oe) |-> !osc_in_pin_o)
    else $error("frame without start bit");
  a_stop_bit_high: assert property ($fell(osc_in_pin_oe) |-> $past(osc_in_pin_o))
    else $error("release without stop bit");
  a_frame_held_on: assert property ($rose(osc_in_pin_oe) |=> osc_in_pin_oe [*8])
    else $error("frame cut short");
  a_chip_lock_kept: assert property (security[1] |=> security[1])
    else $error("chip erase lock cleared");
  c_mode: cover property ($rose(prog_mode));
  c_lock: cover property ($rose(security[1]));
  c_grant: cover property (irq_grant);
  c_alt_pin: cover property ($rose(osc_out_pin_oe));
endmodule : fspp_monitor

// [testbench/fspp_prog_model.sv]
// programmer model: sends commands on the shared wire and collects replies
`timescale 1ns/1ps
`include "fspp_defs.svh"
module fspp_prog_model #(
  parameter int BAUD_DIV = `FSPP_BIT_CYC
) (
  // clock
  input wire logic mclk,
  // shared wire
  input wire logic line,
  output logic drv_o,
  output logic drv_oe
);
  initial begin
    drv_o = 1'b1;
    drv_oe = 1'b0;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : wait_cyc
  // start bit, data lsb first, stop bit
  task automatic send_byte(input logic [7:0] b, input logic last);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    drv_oe = 1'b1;
    for (int i = 0; i < 10; i++) begin
      drv_o = f[i];
      // full stop bit between bytes, so the next start bit cannot meet the stop sample
      wait_cyc((i == 9 && last) ? BAUD_DIV / 2 : BAUD_DIV);
    end
    // wire released mid stop bit of the last byte, pull-up holds it high
    if (last) begin
      drv_oe = 1'b0;
    end
  endtask : send_byte
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    while (line !== 1'b0 && n < 40000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n < 40000) begin
      wait_cyc(BAUD_DIV / 2);
      for (int i = 0; i < 8; i++) begin
        wait_cyc(BAUD_DIV);
        b[i] = line;
      end
      wait_cyc(BAUD_DIV);
      ok = (line === 1'b1);
      wait_cyc(BAUD_DIV / 2);
    end
  endtask : recv_byte
endmodule : fspp_prog_model

// [testbench/test_flash_serial_programming_port.sv]
// self-checking bench for the flash programming port
`timescale 1ns/1ps
`include "fspp_defs.svh"
module test_flash_serial_programming_port;
  logic mclk;
  logic reset_n;
  logic link_sel;
  logic self_prog_busy;
  logic irq_req;
  logic in_o, in_oe, out_o, out_oe, prog_mode, hold, irq_grant, p_o, p_oe, in_w, out_w;
  logic [2:0] security;
  int n_fail = 0;
  int compares = 0;
  // shortened bit period keeps the run brief; the block's default is the 115200 bps count
  localparam int BAUD_DIV = 64;
  // pull-up keeps a released wire high
  assign in_w = in_oe ? in_o : ((!link_sel && p_oe) ? p_o : 1'b1);
  assign out_w = out_oe ? out_o : ((link_sel && p_oe) ? p_o : 1'b1);
  fspp_top #(.BAUD_DIV(BAUD_DIV)) i_dut (.mclk(mclk), .reset_n(reset_n), .link_sel(link_sel), .osc_in_pin_i(in_w),
    .osc_in_pin_o(in_o), .osc_in_pin_oe(in_oe), .osc_out_pin_i(out_w), .osc_out_pin_o(out_o),
    .osc_out_pin_oe(out_oe), .prog_mode(prog_mode), .ports_hold_reset(hold), .security(security),
    .self_prog_busy(self_prog_busy), .irq_req(irq_req), .irq_grant(irq_grant));
  fspp_prog_model #(.BAUD_DIV(BAUD_DIV)) i_prog (.mclk(mclk), .line(link_sel ? out_w : in_w),
    .drv_o(p_o), .drv_oe(p_oe));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic [7:0] q[$], input logic [7:0] exp);
    logic [7:0] b;
    logic ok;
    foreach (q[i]) i_prog.send_byte(q[i], i == q.size() - 1);
    i_prog.recv_byte(b, ok);
    chk({7'h00, ok}, 8'h01);
    chk(b, exp);
  endtask : xfer
  task automatic sum_chk(input logic [7:0] exp);
    logic [7:0] b;
    logic ok;
    xfer('{`FSPP_CMD_CHECKSUM, 8'h01, 8'h00, 8'h00}, exp);
    i_prog.recv_byte(b, ok);
    chk(b, `FSPP_RSP_ACK);
  endtask : sum_chk
  task automatic t_irq;
    // self programming runs on the one fast oscillator clock
    self_prog_busy = 1'b1;
    irq_req = 1'b1;
    i_prog.wait_cyc(3);
    chk({7'h00, irq_grant}, 8'h00);
    self_prog_busy = 1'b0;
    i_prog.wait_cyc(3);
    chk({7'h00, irq_grant}, 8'h01);
    irq_req = 1'b0;
  endtask : t_irq
  task automatic t_enter;
    xfer('{`FSPP_CMD_CHIP_ERASE}, `FSPP_RSP_NAK);
    chk({7'h00, prog_mode}, 8'h00);
    xfer('{`FSPP_CMD_COMM}, `FSPP_RSP_ACK);
    i_prog.wait_cyc(2);
    chk({6'h00, hold, prog_mode}, 8'h03);
  endtask : t_enter
  task automatic t_secure;
    xfer('{`FSPP_CMD_WRITE, 8'h01, 8'h00, 8'h00, 8'hA5}, `FSPP_RSP_ACK);
    sum_chk(8'hA5);
    xfer('{`FSPP_CMD_SECURITY, 8'h05}, `FSPP_RSP_ACK);
    chk({5'h00, security}, 8'h05);
    xfer('{`FSPP_CMD_BLOCK_ERASE, 8'h01}, `FSPP_RSP_NAK);
    sum_chk(8'hA5);
    xfer('{`FSPP_CMD_CHIP_ERASE}, `FSPP_RSP_ACK);
    chk({5'h00, security}, 8'h00);
    sum_chk(`FSPP_ERASED);
    xfer('{`FSPP_CMD_SECURITY, 8'h02}, `FSPP_RSP_ACK);
    xfer('{`FSPP_CMD_CHIP_ERASE}, `FSPP_RSP_NAK);
    chk({5'h00, security}, 8'h02);
  endtask : t_secure
  task automatic t_block;
    xfer('{8'h7E}, `FSPP_RSP_NAK);
    xfer('{`FSPP_CMD_WRITE, 8'h01, 8'h00, 8'h00, 8'hA5}, `FSPP_RSP_ACK);
    xfer('{`FSPP_CMD_BLOCK_ERASE, 8'h00}, `FSPP_RSP_ACK);
    sum_chk(8'hA5);
    xfer('{`FSPP_CMD_BLOCK_ERASE, 8'h01}, `FSPP_RSP_ACK);
    sum_chk(`FSPP_ERASED);
    xfer('{`FSPP_CMD_BLOCK_ERASE, 8'h10}, `FSPP_RSP_NAK);
  endtask : t_block
  task automatic t_alt_pin;
    i_prog.wait_cyc(2);
    link_sel = 1'b1;
    i_prog.wait_cyc(2);
    xfer('{`FSPP_CMD_COMM}, `FSPP_RSP_ACK);
    sum_chk(`FSPP_ERASED);
  endtask : t_alt_pin
  task automatic end_sim;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    repeat (100000) @(posedge mclk);
    n_fail++;
    end_sim();
  end
  initial begin
    // reset is driven by the bench itself; the programmer model has no reset output
    reset_n = 1'b0;
    link_sel = 1'b0;
    self_prog_busy = 1'b0;
    irq_req = 1'b0;
    repeat (16) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    i_prog.wait_cyc(1);
    t_irq();
    t_enter();
    t_block();
    t_secure();
    t_alt_pin();
    end_sim();
  end
endmodule : test_flash_serial_programming_port
bind fspp_top fspp_monitor i_mon (.mclk(mclk), .reset_n(reset_n), .link_sel(link_sel),
  .osc_in_pin_o(osc_in_pin_o), .osc_in_pin_oe(osc_in_pin_oe), .osc_out_pin_oe(osc_out_pin_oe),
  .prog_mode(prog_mode), .ports_hold_reset(ports_hold_reset), .security(security),
  .self_prog_busy(self_prog_busy), .irq_req(irq_req), .irq_grant(irq_grant));
